// *** verilog/usbav_pkg.sv ***
// Package for the USB and FIFO interrupt prioritiser and autovector block
// How it works
// RL1 - USB sources ranked in 32 slots, slot 1 first; vector is four times slot minus one.
// RL2 - Setup ready 00, frame 04, setup token 08, suspend 0C, reset 10, high speed 14, ack 18.
// RL3 - Endpoint zero IN 20, OUT 24; endpoint one IN 28, OUT 2C.
// RL4 - Buffer events for endpoints 2,4,6,8 use codes 30 to 3C.
// RL5 - Bulk IN NAK on any endpoint raises code 40.
// RL6 - Ping NAK codes 48, 4C, then 50 to 5C for endpoints 2,4,6,8.
// RL7 - Error count beyond programmed limit raises code 60.
// RL8 - Isochronous OUT PID sequence errors use codes 70 to 7C.
// RL9 - USB autovector enabled: fetch at 0045 returns USB vector byte.
// RL10 - Firmware lays its jump table within one 256-byte page.
// RL11 - Taking USB interrupt branches to 0043 after pushing the PC.
// RL12 - FIFO group has 14 sources ranked 1 to 14, codes from 80 step four.
// RL13 - Programmable level flags for endpoints 2,4,6,8 use codes 80 to 8C.
// RL14 - Empty flags use codes 90 to 9C at priorities 5 to 8.
// RL15 - Full flags use codes A0 to AC at priorities 9 to 12.
// RL16 - Waveform done uses B0 at 13; waveform event uses B4 at 14.
// RL17 - FIFO autovector enabled: fetch at 0055 returns FIFO vector byte.
// RL18 - Taking FIFO interrupt branches to 0053 after pushing the PC.
// RL19 - Autovector disabled returns memory byte; reserved USB codes never produced.
package usbav_pkg;
   // ****************************************************************
   // Constants
   // ****************************************************************
   localparam int USB_SLOTS = 32;
   localparam int FIFO_SRCS = 14;
   localparam logic [15:0] USB_ENTRY_ADDR = 16'h0043;
   localparam logic [15:0] USB_VEC_ADDR = 16'h0045;
   localparam logic [15:0] FIFO_ENTRY_ADDR = 16'h0053;
   localparam logic [15:0] FIFO_VEC_ADDR = 16'h0055;
   localparam logic [7:0] FIFO_VEC_BASE = 8'h80;
   // Reserved slots 8, 18, 26, 27, 28 sit at bits 7, 17, 25, 26, 27 (codes 1c, 44, 64, 68, 6c)
   localparam logic [31:0] USB_RSVD_MASK = 32'h0e02_0080;
   localparam int IRQ_USB_BIT = 0;
   localparam int IRQ_FIFO_BIT = 1;
   localparam logic [1:0] IRQ_STAT_RESET = 2'h0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [1:0] SETUP_RESET = 2'h0;
   // Register indices on the plain software port
   localparam logic [1:0] REG_SETUP = 2'h0;
   localparam logic [1:0] REG_STAT = 2'h1;
   localparam logic [1:0] REG_MASK = 2'h2;
   localparam logic [1:0] REG_VECS = 2'h3;

   // Fields of interrupt_setup_register
   typedef struct packed {
      logic usb_autovector_enable;
      logic fifo_autovector_enable;
   } usbav_setup_t;

   // Code fetch request and answer
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] mem_data;
   } usbav_fetch_t;
endpackage

// *** verilog/usbav_core.sv ***
// Prioritiser and autovector substitution for the shared USB and FIFO interrupts
`timescale 1ns/1ps
module usbav_core #(
   parameter int USB_N = 32,
   parameter int FIFO_N = 14
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [31:0] usb_req,
   input wire logic [13:0] fifo_req,
   input wire usbav_pkg::usbav_fetch_t fetch,
   output logic [7:0] fetch_data,
   output logic usb_interrupt_line,
   output logic fifo_interrupt_line,
   output logic [7:0] usb_vector_byte,
   output logic [7:0] fifo_vector_byte,
   output logic [15:0] usb_entry_addr,
   output logic [15:0] fifo_entry_addr,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq
);
   // The slot tables are fixed; other widths cannot be served
   initial begin
      if (USB_N != usbav_pkg::USB_SLOTS || FIFO_N != usbav_pkg::FIFO_SRCS) begin
         $error("usbav_core: source counts must be 32 and 14");
      end
   end

   // ****************************************************************
   // Priority encoders
   // ****************************************************************
   // Reserved slots are masked so their codes can never appear
   logic [31:0] usb_live;
   assign usb_live = usb_req & ~usbav_pkg::USB_RSVD_MASK; // RL19

   logic [4:0] usb_win;
   logic usb_any;
   logic [3:0] fifo_win;
   logic fifo_any;

   // Lowest index wins: slot 1 sits at bit 0
   always_comb begin
      usb_win = 5'h0;
      usb_any = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (usb_live[i]) begin
            usb_win = 5'(i); // RL1
            usb_any = 1'b1;
         end
      end
   end

   always_comb begin
      fifo_win = 4'h0;
      fifo_any = 1'b0;
      for (int i = 13; i >= 0; i--) begin
         if (fifo_req[i]) begin
            fifo_win = 4'(i); // RL12
            fifo_any = 1'b1;
         end
      end
   end

   // Vector byte is four times the zero-based slot; the tables fix each source
   // to its bit so codes follow directly (usb bits 0-6, 8-16, 18-24, 28-31)
   wire [7:0] usb_vec_d = {1'b0, usb_win, 2'b00}; // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
   // FIFO codes 80..b4: flags then waveform events
   wire [7:0] fifo_vec_d = usbav_pkg::FIFO_VEC_BASE | {2'b00, fifo_win, 2'b00}; // RL13 RL14 RL15 RL16

   // ****************************************************************
   // Registers
   // ****************************************************************
   usbav_pkg::usbav_setup_t setup_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic usb_any_q;
   logic fifo_any_q;

   // Vector bytes are registered so the fetch sees a stable code
   always_ff @(posedge mclk) begin
      if (rst) begin
         usb_vector_byte <= 8'h00;
         fifo_vector_byte <= usbav_pkg::FIFO_VEC_BASE;
         usb_any_q <= 1'b0;
         fifo_any_q <= 1'b0;
      end else begin
         usb_vector_byte <= usb_vec_d;
         fifo_vector_byte <= fifo_vec_d;
         usb_any_q <= usb_any;
         fifo_any_q <= fifo_any;
      end
   end

   assign usb_interrupt_line = usb_any_q;
   assign fifo_interrupt_line = fifo_any_q;
   // Entry points that the core branches to after pushing its PC
   assign usb_entry_addr = usbav_pkg::USB_ENTRY_ADDR; // RL11
   assign fifo_entry_addr = usbav_pkg::FIFO_ENTRY_ADDR; // RL18

   // Software port decode
   wire wr_setup = reg_wr && reg_addr == usbav_pkg::REG_SETUP;
   wire wr_stat = reg_wr && reg_addr == usbav_pkg::REG_STAT;
   wire wr_mask = reg_wr && reg_addr == usbav_pkg::REG_MASK;
   // Rising group request sets a sticky bit; set beats the write-one clear
   wire [1:0] rise = {fifo_any & ~fifo_any_q, usb_any & ~usb_any_q};
   wire [1:0] stat_d = rise | (stat_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0));

   always_ff @(posedge mclk) begin
      if (rst) begin
         setup_q <= usbav_pkg::SETUP_RESET;
         stat_q <= usbav_pkg::IRQ_STAT_RESET;
         mask_q <= usbav_pkg::IRQ_MASK_RESET;
      end else begin
         stat_q <= stat_d;
         if (wr_setup) begin
            setup_q <= reg_wdata[1:0];
         end
         if (wr_mask) begin
            mask_q <= reg_wdata[1:0];
         end
      end
   end

   assign irq = |(stat_q & mask_q);

   // Read data one cycle after the strobe; other cycles read zero
   always_ff @(posedge mclk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            usbav_pkg::REG_SETUP: reg_rdata <= {6'h00, setup_q};
            usbav_pkg::REG_STAT: reg_rdata <= {6'h00, stat_q};
            usbav_pkg::REG_MASK: reg_rdata <= {6'h00, mask_q};
            default: reg_rdata <= {usb_interrupt_line, fifo_interrupt_line, usb_vector_byte[6:1]};
         endcase
      end
   end

   // ****************************************************************
   // Fetch substitution
   // ****************************************************************
   wire sub_usb = setup_q.usb_autovector_enable && fetch.addr == usbav_pkg::USB_VEC_ADDR;
   wire sub_fifo = setup_q.fifo_autovector_enable && fetch.addr == usbav_pkg::FIFO_VEC_ADDR;

   // Combinational so the byte lands in the same fetch cycle
   assign fetch_data = sub_usb ? usb_vector_byte : // RL9
                       sub_fifo ? fifo_vector_byte : // RL17
                       fetch.mem_data; // RL19

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_usb_sub_byte: assert property (@(posedge mclk) disable iff (rst) // RL9
      sub_usb |-> fetch_data == usb_vector_byte)
      else $error("usb vector not substituted");
   a_fifo_sub_byte: assert property (@(posedge mclk) disable iff (rst) // RL17
      sub_fifo |-> fetch_data == fifo_vector_byte)
      else $error("fifo vector not substituted");
   a_passthru_byte: assert property (@(posedge mclk) disable iff (rst) // RL19
      (fetch.addr != usbav_pkg::USB_VEC_ADDR && fetch.addr != usbav_pkg::FIFO_VEC_ADDR)
      |-> fetch_data == fetch.mem_data)
      else $error("memory byte altered");
   a_usb_top_slot: assert property (@(posedge mclk) disable iff (rst) // RL1
      usb_req[0] |=> usb_vector_byte == 8'h00 && usb_interrupt_line)
      else $error("slot one not first");
   a_usb_rsvd_never: assert property (@(posedge mclk) disable iff (rst) // RL19
      !(usb_vector_byte inside {8'h1c, 8'h44, 8'h64, 8'h68, 8'h6c}))
      else $error("reserved usb code");
   a_usb_err_code: assert property (@(posedge mclk) disable iff (rst) // RL7
      (usb_req[24] && usb_req[23:0] == 24'h0) |=> usb_vector_byte == 8'h60)
      else $error("error limit code wrong");
   a_fifo_top_flag: assert property (@(posedge mclk) disable iff (rst) // RL13
      fifo_req[0] |=> fifo_vector_byte == 8'h80)
      else $error("fifo top code wrong");
   a_fifo_last_src: assert property (@(posedge mclk) disable iff (rst) // RL16
      fifo_req == 14'h2000 |=> fifo_vector_byte == 8'hb4 && fifo_interrupt_line)
      else $error("waveform code wrong");
   a_fifo_full_code: assert property (@(posedge mclk) disable iff (rst) // RL15
      fifo_req[11:0] == 12'h100 |=> fifo_vector_byte == 8'ha0)
      else $error("full flag code wrong");

   // ****************************************************************
   // Per-source code checks
   // ****************************************************************
   // Each live slot that wins alone must give four times its zero-based index
   for (genvar s = 0; s < 32; s++) begin : g_usb_slot
      if (!usbav_pkg::USB_RSVD_MASK[s]) begin : g_live
         a_usb_slot_code: assert property (@(posedge mclk) disable iff (rst) // RL1
            (usb_live[s] && (usb_live & ((32'h1 << s) - 32'h1)) == 32'h0)
            |=> usb_vector_byte == 8'(4 * s))
            else $error("usb slot code wrong");
      end
   end

   // FIFO sources step by four from the group base
   for (genvar f = 0; f < 14; f++) begin : g_fifo_src
      a_fifo_src_code: assert property (@(posedge mclk) disable iff (rst) // RL12
         (fifo_req[f] && (fifo_req & ((14'h1 << f) - 14'h1)) == 14'h0)
         |=> fifo_vector_byte == 8'(128 + 4 * f))
         else $error("fifo source code wrong");
   end

   // Lines follow the live requests one cycle later
   a_usb_line_follow: assert property (@(posedge mclk) disable iff (rst) // RL1
      usb_any |=> usb_interrupt_line)
      else $error("usb line missed");
   a_fifo_line_follow: assert property (@(posedge mclk) disable iff (rst) // RL12
      fifo_any |=> fifo_interrupt_line)
      else $error("fifo line missed");
   // A new USB event must survive a clear written in the same cycle
   a_stat_set_wins: assert property (@(posedge mclk) disable iff (rst) // RL1
      rise[0] |=> stat_q[0])
      else $error("status set lost");
   // Read data stands only in the cycle after a read strobe
   a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (rst) // RL19
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not cleared");
endmodule

// *** verification/usbav_core_model.sv ***
// Code memory model on the core side of the fetch port
`timescale 1ns/1ps
module usbav_core_model (
   input wire logic [15:0] addr,
   output usbav_pkg::usbav_fetch_t fetch
);
   // Page byte sits below each vector-low slot; other bytes vary per address
   assign fetch.addr = addr;
   assign fetch.mem_data = (addr[3:0] == 4'h4) ? 8'h3f : (addr[7:0] ^ 8'h5a);
endmodule

// *** verification/usbav_core_tb.sv ***
// Self-checking bench for the interrupt prioritiser and autovector block
`timescale 1ns/1ps
module usbav_core_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] usb_req = 32'h0;
   logic [13:0] fifo_req = 14'h0;
   logic [15:0] addr = 16'h0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   usbav_pkg::usbav_fetch_t fetch;
   logic [7:0] fdata, uvec, fvec, rdata, d;
   logic uline, fline, irq;
   logic [15:0] uent, fent;
   int n_mismatch = 0;
   int checked = 0;
   typedef struct packed {logic [31:0] u; logic [13:0] f; logic [7:0] eu; logic [7:0] ef;} usbav_row_t;
   // Rows mix several requests; reserved bits must lose even to lower-ranked live slots
   usbav_row_t rows [4] = '{'{32'h6, 14'h3000, 8'h04, 8'hb0},
      '{32'h180, 14'h110, 8'h20, 8'h90}, '{32'h8e00_0000, 14'h2001, 8'h7c, 8'h80},
      '{32'h3_0000, 14'h0, 8'h40, 8'h80}};
   usbav_core u_dut (.mclk(mclk), .rst(rst), .usb_req(usb_req), .fifo_req(fifo_req),
      .fetch(fetch), .fetch_data(fdata), .usb_interrupt_line(uline),
      .fifo_interrupt_line(fline), .usb_vector_byte(uvec), .fifo_vector_byte(fvec),
      .usb_entry_addr(uent), .fifo_entry_addr(fent), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq));
   usbav_core_model u_mem (.addr(addr), .fetch(fetch));
   always #50 mclk = ~mclk;
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Requests land one edge, vectors are looked at after the next
   task automatic req(input logic [31:0] u, input logic [13:0] f);
      @(posedge mclk);
      usb_req <= u;
      fifo_req <= f;
      @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk(uvec, 8'h00);
      chk(fvec, 8'h80);
      chk({uline, fline, irq, rdata[4:0]}, 8'h00);
      chk(uent[7:0], 8'h43);
      chk(fent[7:0], 8'h53);
      chk(uent[15:8] | fent[15:8], 8'h00);
      foreach (rows[k]) begin
         req(rows[k].u, rows[k].f);
         chk(uvec, rows[k].eu);
         chk(fvec, rows[k].ef);
      end
      $display("rows done");
      // Every slot alone; reserved slots must stay silent
      for (int i = 0; i < 32; i++) begin
         automatic logic rsv = (i == 7 || i == 17 || (i >= 25 && i <= 27));
         req(32'h1 << i, (i < 14) ? (14'h1 << i) : 14'h0);
         chk(uvec, rsv ? 8'h00 : 8'(i * 4));
         chk({uline, fline, 6'h0}, {!rsv, i < 14, 6'h0});
         if (i < 14) chk(fvec, 8'(8'h80 + i * 4));
      end
      $display("sweep done");
      // Substitution on at both vector-low bytes, then off at the USB one only
      req(32'h10, 14'h2000);
      wr(usbav_pkg::REG_SETUP, 8'h03);
      rd(usbav_pkg::REG_SETUP);
      chk(d, 8'h03);
      addr <= 16'h0045;
      #1;
      chk(fdata, 8'h10);
      addr <= 16'h0055;
      #1;
      chk(fdata, 8'hb4);
      addr <= 16'h0044;
      #1;
      chk(fdata, 8'h3f);
      wr(usbav_pkg::REG_SETUP, 8'h01);
      addr <= 16'h0045;
      #1;
      chk(fdata, 8'h1f);
      addr <= 16'h0055;
      #1;
      chk(fdata, 8'hb4);
      rd(2'h3);
      chk(d, 8'hc8);
      $display("fetch done");
      // Sticky status, mask and clear by writing one
      req(32'h0, 14'h0);
      wr(usbav_pkg::REG_STAT, 8'h03);
      wr(usbav_pkg::REG_MASK, 8'h01);
      req(32'h10, 14'h1);
      for (int k = 0; k < 5 && irq !== 1'b1; k++) @(posedge mclk);
      #1;
      chk(irq, 1'b1);
      if (irq !== 1'b1) report_and_stop();
      rd(usbav_pkg::REG_STAT);
      chk(d, 8'h03);
      wr(usbav_pkg::REG_STAT, 8'h01);
      req(32'h10, 14'h1);
      chk(irq, 1'b0);
      rd(usbav_pkg::REG_STAT);
      chk(d, 8'h02);
      wr(usbav_pkg::REG_MASK, 8'h03);
      #1;
      chk(irq, 1'b1);
      $display("irq done");
      // Reset in mid-run with requests still held
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk({uvec, fvec[7]}, {8'h00, 1'b1});
      chk({irq, uline}, 2'h0);
      rd(usbav_pkg::REG_SETUP);
      chk(d, 8'h00);
      $display("reset done");
      report_and_stop();
   end
endmodule
